// File: design/eps_page_sender.sv
// page sender: shifts one 8-byte page out as addressed bytes, msb first.
// assumes the eeprom engine takes a byte when valid and ready are both high.
module eps_page_sender
    import eps_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [PAGE_BITS-1:0] page,
    input wire logic [7:0] base_addr,
    output logic busy,
    output logic ee_valid,
    output logic [7:0] ee_addr,
    output logic [7:0] ee_data,
    output logic ee_last,
    input wire logic ee_ready
);
    typedef enum logic [0:0] {EPS_IDLE, EPS_SEND} eps_snd_t;
    eps_snd_t state_r, state_nxt;
    logic [PAGE_BITS-1:0] shift_r, shift_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [BYTE_CNT_W-1:0] cnt_r, cnt_nxt;

    // next state: load on start, advance one byte per accepted handshake
    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        addr_nxt = addr_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            EPS_IDLE: begin
                if (start) begin
                    state_nxt = EPS_SEND;
                    shift_nxt = page;
                    addr_nxt = base_addr;
                    cnt_nxt = '0;
                end
            end
            EPS_SEND: begin
                if (ee_ready) begin
                    shift_nxt = {shift_r[PAGE_BITS-9:0], 8'h00};
                    addr_nxt = addr_r + 8'h01;
                    cnt_nxt = cnt_r + 3'h1;
                    if (cnt_r == 3'h7) begin
                        state_nxt = EPS_IDLE;
                    end
                end
            end
        endcase
    end

    // registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= EPS_IDLE;
            shift_r <= '0;
            addr_r <= '0;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            addr_r <= addr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // outputs straight from the registers
    assign busy = (state_r == EPS_SEND);
    assign ee_valid = (state_r == EPS_SEND);
    assign ee_addr = addr_r;
    assign ee_data = shift_r[PAGE_BITS-1 -: 8];
    assign ee_last = (state_r == EPS_SEND) && (cnt_r == 3'h7);
endmodule

// File: design/eps_pkg.sv
// constants for the eeprom parameter staging bank: register offsets,
// field positions, reset values and eeprom byte addresses of each page.
// assumes a byte-addressed register port with 32-bit aligned words.
package eps_pkg;
    localparam int ADDR_W = 12;
    // register byte offsets within the register window
    localparam logic [11:0] OFS_SUBSYS = 12'h930;
    localparam logic [11:0] OFS_BUSLAT = 12'h934;
    localparam logic [11:0] OFS_UID_HI = 12'h938;
    localparam logic [11:0] OFS_UID_LO = 12'h93C;
    localparam logic [11:0] OFS_PAGE_CTL = 12'h940;
    localparam logic [11:0] OFS_LAT_TMR = 12'h950;
    localparam logic [11:0] OFS_GENERAL0 = 12'h954;
    localparam logic [11:0] OFS_PHY_EN = 12'h960;
    localparam logic [11:0] OFS_CIS_EVEN = 12'h980;
    localparam logic [11:0] OFS_CIS_ODD = 12'h984;
    localparam int GENERAL_WORDS = 3;
    // field positions
    localparam int SUBSYS_ID_LSB = 16;
    localparam int MAX_LAT_LSB = 24;
    localparam int MIN_GNT_LSB = 16;
    localparam int MAX_REC_LSB = 0;
    localparam int LAT_TMR_LSB = 3;
    localparam int PAGE_SEL_LSB = 4;
    localparam int STROBE_BIT = 0;
    localparam int PHY_PROG_BIT = 9;
    localparam int PHY_ENH_BIT = 8;
    localparam int BUSY_BIT = 31;
    localparam int CIS_IDX_LSB = 8;
    // reset values
    localparam logic [7:0] MAX_LAT_RST = 8'h00;
    localparam logic [7:0] MIN_GNT_RST = 8'h00;
    localparam logic [3:0] MAX_REC_RST = 4'h9;
    localparam logic [4:0] LAT_TMR_RST = 5'h00;
    localparam logic [2:0] PAGE_SEL_RST = 3'h0;
    localparam logic PHY_PROG_RST = 1'b1;
    localparam logic PHY_ENH_RST = 1'b0;
    // page selector codes
    localparam logic [2:0] PG_SUBSYS = 3'h0;
    localparam logic [2:0] PG_UID = 3'h1;
    localparam logic [2:0] PG_LAT_GEN0 = 3'h2;
    localparam logic [2:0] PG_GEN12 = 3'h3;
    localparam logic [2:0] PG_PHY = 3'h4;
    localparam logic [2:0] PG_CIS = 3'h5;
    // eeprom byte addresses of each page and fixed filler bytes
    localparam logic [7:0] EE_SUBSYS = 8'h00;
    localparam logic [7:0] EE_UID = 8'h08;
    localparam logic [7:0] EE_LAT_GEN0 = 8'h10;
    localparam logic [7:0] EE_GEN12 = 8'h18;
    localparam logic [7:0] EE_PHY = 8'h20;
    localparam logic [7:0] EE_CIS = 8'h28;
    localparam logic [7:0] BUSLAT_FIXED_BYTE = 8'h08;
    localparam logic [7:0] PHY_FIXED_BYTE = 8'h07;
    localparam int CIS_IDX_W = 4;
    localparam int PAGE_BYTES = 8;
    localparam int PAGE_BITS = PAGE_BYTES * 8;
    localparam int BYTE_CNT_W = 3;
endpackage

// File: design/eps_staging.sv
// staging bank: parameter registers, page write control and the values
// offered to configuration space. assumes a single-cycle register port
// (one write or read per cycle) and an eeprom engine taking addressed bytes.
// card_mode is a device pin and is synchronised here.

module eps_staging
    import eps_pkg::*;
#(
    parameter logic [15:0] SUBSYS_ID_RST = 16'h0001, // arbitrary value
    parameter logic [15:0] SUBSYS_VENDOR_RST = 16'h0001 // arbitrary value
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic card_mode,
    output logic [15:0] cfg_subsys_id,
    output logic [15:0] cfg_subsys_vendor,
    output logic [7:0] cfg_max_latency,
    output logic [7:0] cfg_min_grant,
    output logic [3:0] cfg_max_rec,
    output logic [63:0] cfg_unique_id,
    output logic [4:0] cfg_latency_timer,
    output logic cfg_latency_timer_load,
    output logic [95:0] cfg_general,
    output logic cfg_phy_program_en,
    output logic cfg_phy_enhance_en,
    output logic [63:0] cfg_card_info,
    output logic page_busy,
    output logic ee_valid,
    output logic [7:0] ee_addr,
    output logic [7:0] ee_data,
    output logic ee_last,
    input wire logic ee_ready
);
    logic [15:0] staged_subsystem_id_r, staged_subsystem_id_nxt;
    logic [15:0] staged_subsystem_vendor_r, staged_subsystem_vendor_nxt;
    logic [7:0] staged_max_latency_r, staged_max_latency_nxt;
    logic [7:0] staged_min_grant_r, staged_min_grant_nxt;
    logic [3:0] staged_max_rec_r, staged_max_rec_nxt;
    logic [31:0] staged_unique_id_high_r, staged_unique_id_high_nxt;
    logic [31:0] staged_unique_id_low_r, staged_unique_id_low_nxt;
    logic [4:0] staged_latency_timer_r, staged_latency_timer_nxt;
    logic [31:0] general_r [GENERAL_WORDS];
    logic [31:0] general_nxt [GENERAL_WORDS];
    logic staged_phy_program_en_r, staged_phy_program_en_nxt;
    logic staged_phy_enhance_en_r, staged_phy_enhance_en_nxt;
    logic [31:0] card_info_even_word_r, card_info_even_word_nxt;
    logic [31:0] card_info_odd_word_r, card_info_odd_word_nxt;
    logic [CIS_IDX_W-1:0] cis_idx_r, cis_idx_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic mode_meta_r, mode_sync_r;
    logic send_busy;
    logic page_write_strobe;
    logic [2:0] page_sel;
    logic [PAGE_BITS-1:0] page_img;
    logic [7:0] page_base;

    // true when a register write hits the given offset
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    // strobe and selector; a strobe while a page is in flight is dropped
    assign page_sel = reg_wdata[PAGE_SEL_LSB +: 3];
    assign page_write_strobe = reg_wr && hit(reg_addr, OFS_PAGE_CTL)
        && reg_wdata[STROBE_BIT] && !send_busy;

    // page image and its eeprom base address, fixed bytes filled in
    always_comb begin
        page_img = '0;
        page_base = EE_SUBSYS;
        unique case (page_sel)
            PG_SUBSYS: begin
                page_base = EE_SUBSYS;
                page_img = {staged_subsystem_id_r, staged_subsystem_vendor_r,
                    staged_max_latency_r, staged_min_grant_r,
                    BUSLAT_FIXED_BYTE, 4'h0, staged_max_rec_r};
            end
            PG_UID: begin
                page_base = EE_UID;
                page_img = {staged_unique_id_high_r, staged_unique_id_low_r};
            end
            PG_LAT_GEN0: begin
                page_base = EE_LAT_GEN0;
                page_img = {24'h000000, staged_latency_timer_r, 3'h0,
                    general_r[0]};
            end
            PG_GEN12: begin
                page_base = EE_GEN12;
                page_img = {general_r[1], general_r[2]};
            end
            PG_PHY: begin
                page_base = EE_PHY;
                page_img = {16'h0000, 6'h00, staged_phy_program_en_r,
                    staged_phy_enhance_en_r, PHY_FIXED_BYTE,
                    32'h00000000};
            end
            PG_CIS: begin
                page_base = EE_CIS + {1'b0, cis_idx_r, 3'h0};
                page_img = {card_info_even_word_r, card_info_odd_word_r};
            end
            default: begin
                page_base = EE_SUBSYS;
                page_img = '0;
            end
        endcase
    end

    // register file next values: written fields update, cis_idx_r steps on a cis page strobe, others hold
    always_comb begin
        staged_subsystem_id_nxt = staged_subsystem_id_r;
        staged_subsystem_vendor_nxt = staged_subsystem_vendor_r;
        staged_max_latency_nxt = staged_max_latency_r;
        staged_min_grant_nxt = staged_min_grant_r;
        staged_max_rec_nxt = staged_max_rec_r;
        staged_unique_id_high_nxt = staged_unique_id_high_r;
        staged_unique_id_low_nxt = staged_unique_id_low_r;
        staged_latency_timer_nxt = staged_latency_timer_r;
        for (int i = 0; i < GENERAL_WORDS; i++) begin
            general_nxt[i] = general_r[i];
        end
        staged_phy_program_en_nxt = staged_phy_program_en_r;
        staged_phy_enhance_en_nxt = staged_phy_enhance_en_r;
        card_info_even_word_nxt = card_info_even_word_r;
        card_info_odd_word_nxt = card_info_odd_word_r;
        cis_idx_nxt = cis_idx_r;
        if (page_write_strobe && page_sel == PG_CIS) begin
            cis_idx_nxt = cis_idx_r + 4'h1; // next cis pair slot
        end
        if (reg_wr) begin
            if (hit(reg_addr, OFS_SUBSYS)) begin
                staged_subsystem_id_nxt =
                    reg_wdata[SUBSYS_ID_LSB +: 16];
                staged_subsystem_vendor_nxt = reg_wdata[15:0];
            end
            if (hit(reg_addr, OFS_BUSLAT)) begin
                staged_max_latency_nxt = reg_wdata[MAX_LAT_LSB +: 8];
                staged_min_grant_nxt = reg_wdata[MIN_GNT_LSB +: 8];
                staged_max_rec_nxt = reg_wdata[MAX_REC_LSB +: 4];
            end
            if (hit(reg_addr, OFS_UID_HI)) begin
                staged_unique_id_high_nxt = reg_wdata;
            end
            if (hit(reg_addr, OFS_UID_LO)) begin
                staged_unique_id_low_nxt = reg_wdata;
            end
            if (hit(reg_addr, OFS_LAT_TMR)) begin
                staged_latency_timer_nxt =
                    reg_wdata[LAT_TMR_LSB +: 5];
            end
            for (int i = 0; i < GENERAL_WORDS; i++) begin
                if (hit(reg_addr, OFS_GENERAL0 + 12'(4 * i))) begin
                    general_nxt[i] = reg_wdata;
                end
            end
            if (hit(reg_addr, OFS_PHY_EN)) begin
                staged_phy_program_en_nxt = reg_wdata[PHY_PROG_BIT];
                staged_phy_enhance_en_nxt = reg_wdata[PHY_ENH_BIT];
            end
            if (hit(reg_addr, OFS_CIS_EVEN)) begin
                card_info_even_word_nxt = reg_wdata;
            end
            if (hit(reg_addr, OFS_CIS_ODD)) begin
                card_info_odd_word_nxt = reg_wdata;
            end
        end
    end

    // read data, one cycle after the read; reserved bits read zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            rdata_nxt = 32'h00000000;
            unique case (reg_addr)
                OFS_SUBSYS: rdata_nxt = {staged_subsystem_id_r,
                    staged_subsystem_vendor_r};
                OFS_BUSLAT: rdata_nxt = {staged_max_latency_r,
                    staged_min_grant_r, 12'h000, staged_max_rec_r};
                OFS_UID_HI: rdata_nxt = staged_unique_id_high_r;
                OFS_UID_LO: rdata_nxt = staged_unique_id_low_r;
                OFS_PAGE_CTL: rdata_nxt = {send_busy, 19'h00000, cis_idx_r,
                    8'h00};
                OFS_LAT_TMR: rdata_nxt = {24'h000000,
                    staged_latency_timer_r, 3'h0};
                OFS_GENERAL0: rdata_nxt = general_r[0];
                OFS_GENERAL0 + 12'h004: rdata_nxt = general_r[1];
                OFS_GENERAL0 + 12'h008: rdata_nxt = general_r[2];
                OFS_PHY_EN: rdata_nxt = {22'h000000, staged_phy_program_en_r,
                    staged_phy_enhance_en_r, 8'h00};
                OFS_CIS_EVEN: rdata_nxt = card_info_even_word_r;
                OFS_CIS_ODD: rdata_nxt = card_info_odd_word_r;
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            staged_subsystem_id_r <= SUBSYS_ID_RST;
            staged_subsystem_vendor_r <= SUBSYS_VENDOR_RST;
            staged_max_latency_r <= MAX_LAT_RST;
            staged_min_grant_r <= MIN_GNT_RST;
            staged_max_rec_r <= MAX_REC_RST;
            staged_unique_id_high_r <= '0;
            staged_unique_id_low_r <= '0;
            staged_latency_timer_r <= LAT_TMR_RST;
            for (int i = 0; i < GENERAL_WORDS; i++) begin
                general_r[i] <= '0;
            end
            staged_phy_program_en_r <= PHY_PROG_RST;
            staged_phy_enhance_en_r <= PHY_ENH_RST;
            card_info_even_word_r <= '0;
            card_info_odd_word_r <= '0;
            cis_idx_r <= '0;
            rdata_r <= '0;
            mode_meta_r <= 1'b0;
            mode_sync_r <= 1'b0;
        end else begin
            staged_subsystem_id_r <= staged_subsystem_id_nxt;
            staged_subsystem_vendor_r <= staged_subsystem_vendor_nxt;
            staged_max_latency_r <= staged_max_latency_nxt;
            staged_min_grant_r <= staged_min_grant_nxt;
            staged_max_rec_r <= staged_max_rec_nxt;
            staged_unique_id_high_r <= staged_unique_id_high_nxt;
            staged_unique_id_low_r <= staged_unique_id_low_nxt;
            staged_latency_timer_r <= staged_latency_timer_nxt;
            for (int i = 0; i < GENERAL_WORDS; i++) begin
                general_r[i] <= general_nxt[i];
            end
            staged_phy_program_en_r <= staged_phy_program_en_nxt;
            staged_phy_enhance_en_r <= staged_phy_enhance_en_nxt;
            card_info_even_word_r <= card_info_even_word_nxt;
            card_info_odd_word_r <= card_info_odd_word_nxt;
            cis_idx_r <= cis_idx_nxt;
            rdata_r <= rdata_nxt;
            mode_meta_r <= card_mode; // pin synchroniser
            mode_sync_r <= mode_meta_r;
        end
    end

    // page transmitter toward the eeprom engine
    eps_page_sender u_sender (
        .clock(clock),
        .rst_n(rst_n),
        .start(page_write_strobe),
        .page(page_img),
        .base_addr(page_base),
        .busy(send_busy),
        .ee_valid(ee_valid),
        .ee_addr(ee_addr),
        .ee_data(ee_data),
        .ee_last(ee_last),
        .ee_ready(ee_ready)
    );

    // values offered to configuration and host-controller registers
    assign reg_rdata = rdata_r;
    assign page_busy = send_busy;
    assign cfg_subsys_id = staged_subsystem_id_r;
    assign cfg_subsys_vendor = staged_subsystem_vendor_r;
    assign cfg_max_latency = staged_max_latency_r;
    assign cfg_min_grant = staged_min_grant_r;
    assign cfg_max_rec = staged_max_rec_r;
    assign cfg_unique_id = {staged_unique_id_high_r, staged_unique_id_low_r};
    assign cfg_latency_timer = staged_latency_timer_r;
    assign cfg_latency_timer_load = mode_sync_r;
    assign cfg_general = {general_r[0], general_r[1], general_r[2]};
    assign cfg_phy_program_en = staged_phy_program_en_r;
    assign cfg_phy_enhance_en = staged_phy_enhance_en_r;
    assign cfg_card_info = {card_info_even_word_r, card_info_odd_word_r};
endmodule

// File: sim/eps_eeprom_model.sv
// behavioural eeprom engine: takes addressed bytes on valid and ready,
// stalling at random when asked. assumes the bank's single clock.
module eps_eeprom_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic stall_en,
    input wire logic ee_valid,
    input wire logic [7:0] ee_addr,
    input wire logic [7:0] ee_data,
    input wire logic ee_last,
    output logic ee_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [256];
    int rx_count = 0;
    int pm_seed = 78266;
    int rnd;
    // stores each accepted byte and draws the next ready level
    always @(posedge clock) begin
        rnd = $random(pm_seed);
        if (rst_n && ee_valid && ee_ready) begin
            mem[ee_addr] <= ee_data;
            rx_count <= rx_count + 1;
        end
        ee_ready <= rst_n && (!stall_en || rnd[0]);
    end
endmodule

// File: sim/eps_staging_monitor.sv
// checker for the staging bank: page launch, byte handshake, reset values.
// assumes it is bound to eps_staging and sees only that module's ports.
module eps_staging_monitor
    import eps_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    input wire logic card_mode,
    input wire logic [63:0] cfg_unique_id,
    input wire logic [7:0] cfg_max_latency,
    input wire logic [3:0] cfg_max_rec,
    input wire logic cfg_latency_timer_load,
    input wire logic cfg_phy_program_en,
    input wire logic cfg_phy_enhance_en,
    input wire logic page_busy,
    input wire logic ee_valid,
    input wire logic [7:0] ee_addr,
    input wire logic [7:0] ee_data,
    input wire logic ee_last,
    input wire logic ee_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_r, cnt_nxt, pg_r, pg_nxt;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // counts accepted bytes and keeps the page code last offered
    always_comb begin
        cnt_nxt = (ee_valid && ee_ready) ? cnt_r + 3'h1 : cnt_r;
        pg_nxt = reg_wdata[6:4];
    end
    always_ff @(posedge clock) begin
        cnt_r <= rst_n ? cnt_nxt : 3'h0;
        pg_r <= pg_nxt;
    end
    sequence s_start;
        reg_wr && reg_addr == OFS_PAGE_CTL && reg_wdata[0] && !page_busy;
    endsequence
    sequence s_last;
        ee_valid && ee_ready && ee_last;
    endsequence
    property p_start;
        s_start |=> page_busy && ee_valid && (pg_r == 3'h5 ||
            ee_addr == (pg_r > 3'h5 ? 8'h00 : {2'h0, pg_r, 3'h0}));
    endproperty
    property p_zero;
        reg_wr && reg_addr == OFS_PAGE_CTL && !reg_wdata[0] && !page_busy
            |=> !page_busy;
    endproperty
    property p_hold;
        ee_valid && !ee_ready |=> ee_valid && $stable(ee_addr)
            && $stable(ee_data);
    endproperty
    property p_step;
        ee_valid && ee_ready && !ee_last |=> ee_valid
            && ee_addr == $past(ee_addr) + 8'h01;
    endproperty
    property p_end;
        s_last |=> !ee_valid && !page_busy;
    endproperty
    property p_pair;
        page_busy == ee_valid
            && (!$fell(page_busy) || $past(ee_ready && ee_last));
    endproperty
    property p_count;
        ee_valid |-> ee_last == (cnt_r == 3'h7);
    endproperty
    property p_rst;
        $rose(rst_n) |-> cfg_max_rec == 4'h9 && cfg_max_latency == 8'h00
            && cfg_phy_program_en && !cfg_phy_enhance_en;
    endproperty
    property p_uid;
        reg_wr && reg_addr == OFS_UID_HI |=>
            cfg_unique_id[63:32] == $past(reg_wdata);
    endproperty
    property p_load;
        $past(rst_n) && $past(rst_n, 2) |->
            cfg_latency_timer_load == $past(card_mode, 2);
    endproperty
    a_start: assert property (p_start)
        else $error("page launch missing");
    a_zero: assert property (p_zero)
        else $error("zero strobe started a page");
    a_hold: assert property (p_hold)
        else $error("byte changed while stalled");
    a_step: assert property (p_step)
        else $error("byte address did not step");
    a_end: assert property (p_end)
        else $error("page did not end after last byte");
    a_pair: assert property (p_pair)
        else $error("busy and valid disagree");
    a_count: assert property (p_count)
        else $error("page not eight bytes");
    a_rst: assert property (p_rst)
        else $error("reset value wrong");
    a_uid: assert property (p_uid)
        else $error("identifier high not staged");
    a_load: assert property (p_load)
        else $error("latency load does not follow mode pin");
endmodule

bind eps_staging eps_staging_monitor mon_u (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .card_mode(card_mode), .cfg_unique_id(cfg_unique_id),
    .cfg_max_latency(cfg_max_latency), .cfg_max_rec(cfg_max_rec),
    .cfg_latency_timer_load(cfg_latency_timer_load),
    .cfg_phy_program_en(cfg_phy_program_en),
    .cfg_phy_enhance_en(cfg_phy_enhance_en), .page_busy(page_busy),
    .ee_valid(ee_valid), .ee_addr(ee_addr), .ee_data(ee_data),
    .ee_last(ee_last), .ee_ready(ee_ready));

// File: sim/eps_staging_tb_top.sv
// testbench for the staging bank: register access, page commits, reset
// values, mode pin. assumes the eeprom model and bound monitor are built.
module eps_staging_tb_top import eps_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] ID_RST = 16'h0001; // arbitrary value
    localparam logic [11:0] ADDRS [11] = '{OFS_SUBSYS, OFS_BUSLAT,
        OFS_UID_HI, OFS_UID_LO, OFS_LAT_TMR, OFS_GENERAL0, 12'h958,
        12'h95C, OFS_PHY_EN, OFS_CIS_EVEN, OFS_CIS_ODD};
    localparam logic [31:0] MASKS [11] = '{32'hFFFFFFFF, 32'hFFFF000F,
        32'hFFFFFFFF, 32'hFFFFFFFF, 32'h000000F8, 32'hFFFFFFFF,
        32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00000300, 32'hFFFFFFFF,
        32'hFFFFFFFF};
    logic clock, rst_n, reg_wr, reg_rd, card_mode, stall_en, page_busy;
    logic ee_valid, ee_last, ee_ready, lt_load, prog_en, enh_en;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic [15:0] sub_id, sub_vnd;
    logic [7:0] max_lat, min_gnt, ee_addr, ee_data;
    logic [3:0] max_rec;
    logic [4:0] lat_tmr;
    logic [63:0] uid, cis, pv;
    logic [95:0] gen;
    logic [31:0] sh [11];
    int err_count = 0;
    int total_checks = 0;
    int seed = 78266;
    int idx = 0;
    int rx0;
    eps_staging #(.SUBSYS_ID_RST(ID_RST), .SUBSYS_VENDOR_RST(ID_RST)) dut_u (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .card_mode(card_mode), .cfg_subsys_id(sub_id),
        .cfg_subsys_vendor(sub_vnd), .cfg_max_latency(max_lat),
        .cfg_min_grant(min_gnt), .cfg_max_rec(max_rec),
        .cfg_unique_id(uid), .cfg_latency_timer(lat_tmr),
        .cfg_latency_timer_load(lt_load), .cfg_general(gen),
        .cfg_phy_program_en(prog_en), .cfg_phy_enhance_en(enh_en),
        .cfg_card_info(cis), .page_busy(page_busy), .ee_valid(ee_valid),
        .ee_addr(ee_addr), .ee_data(ee_data), .ee_last(ee_last),
        .ee_ready(ee_ready));
    eps_eeprom_model ee_u (.clock(clock), .rst_n(rst_n),
        .stall_en(stall_en), .ee_valid(ee_valid), .ee_addr(ee_addr),
        .ee_data(ee_data), .ee_last(ee_last), .ee_ready(ee_ready));
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic wait_idle();
        int n = 0;
        #1;
        while (page_busy !== 1'b0 && n < 300) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk(page_busy, 1'b0);
    endtask
    // expected eight bytes of a page, first byte in the top position
    function automatic logic [63:0] page_val(input int pg);
        case (pg)
            0: return {sh[0], sh[1][31:16], 8'h08, 4'h0, sh[1][3:0]};
            1: return {sh[2], sh[3]};
            2: return {24'h0, sh[4][7:3], 3'h0, sh[5]};
            3: return {sh[6], sh[7]};
            4: return {22'h0, sh[8][9:8], 8'h07, 32'h0};
            5: return {sh[9], sh[10]};
            default: return 64'h0;
        endcase
    endfunction
    task automatic check_page(input int pg);
        int b;
        pv = page_val(pg);
        b = pg < 5 ? pg * 8 : (pg == 5 ? 40 + 8 * idx : 0);
        for (int i = 0; i < 8; i++)
            chk(ee_u.mem[b + i], pv[63 - 8 * i -: 8]);
        chk(ee_u.rx_count - rx0, 8);
        if (pg == 5)
            idx = (idx + 1) % 16;
    endtask
    task automatic readback();
        for (int i = 0; i < 11; i++) begin
            rd(ADDRS[i], v);
            chk(v, sh[i] & MASKS[i]);
        end
        rd(OFS_PAGE_CTL, v);
        chk(v, {20'h0, idx[3:0], 8'h0});
        chk({sub_id, sub_vnd, uid}, {sh[0], sh[2], sh[3]});
        chk(gen, {sh[5], sh[6], sh[7]});
        chk({cis, max_lat, min_gnt}, {sh[9], sh[10], sh[1][31:16]});
        chk({max_rec, lat_tmr, prog_en, enh_en},
            {sh[1][3:0], sh[4][7:3], sh[8][9:8]});
    endtask
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        end_sim();
    end
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 32'h0;
        card_mode = 1'b0;
        stall_en = 1'b0;
        sh = '{{ID_RST, ID_RST}, 32'h9, 0, 0, 0, 0, 0, 0, 32'h200, 0, 0};
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        chk({page_busy, ee_valid, lt_load}, 3'h0);
        readback();
        wr(12'h944, 32'hFFFFFFFF);
        rd(12'h944, v);
        chk(v, 32'h0);
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 11; i++) begin
                v = $random(seed) & MASKS[i];
                if (i == 1)
                    v = v | 32'h800;
                if (i == 8)
                    v = v | 32'h7;
                wr(ADDRS[i], v);
                sh[i] = v;
            end
            readback();
            @(posedge clock);
            stall_en <= r[0];
            for (int pg = 0; pg < 8; pg++)
                commit(pg);
            readback();
        end
        rx0 = ee_u.rx_count;
        wr(OFS_PAGE_CTL, 32'h00000011);
        rd(OFS_PAGE_CTL, v);
        chk(v, {1'b1, 19'h0, idx[3:0], 8'h0});
        wr(OFS_PAGE_CTL, 32'h00000031);
        wait_idle();
        repeat (3) @(posedge clock);
        check_page(1);
        rx0 = ee_u.rx_count;
        wr(OFS_PAGE_CTL, 32'h00000050);
        #1;
        chk({page_busy, ee_u.rx_count - rx0}, 33'h0);
        for (int k = 1; k >= 0; k--) begin
            @(posedge clock);
            card_mode <= k[0];
            repeat (3) @(posedge clock);
            #1;
            chk(lt_load, k[0]);
        end
        end_sim();
    end
    task automatic commit(input int pg);
        rx0 = ee_u.rx_count;
        wr(OFS_PAGE_CTL, {25'h0, pg[2:0], 4'h1});
        wait_idle();
        check_page(pg);
    endtask
endmodule
